/* wrc_consts.svh */
// Constants for the wake-up and resume controller
// Notes on behaviour
// (R01) Wake event sets its own wake flag
// (R02) Unmasked event wakes or resumes into Run
// (R03) Writing one clears that wake flag
// (R04) Wake flags never clear themselves
// (R05) Thermal release and interval timer unmaskable
// (R06) Masked event never wakes or resumes
// (R07) Timers resume Idle; sampling and interval also Stand-By
// (R08) Sampling timer sets flag, resumes Idle and Stand-By
// (R09) Sampling timer reloads itself each period
// (R10) Sampling timer ticks at 90 kHz
// (R11) Interval timer runs from reset, never disabled
// (R12) 9 bit pre-counter feeds 12 bit post-counter
// (R13) Pre-counter counts in every state
// (R14) Three 10 bit monitor counters, zero disables
// (R15) Monitor counters ticked by the pre-counter
// (R16) Monitor elapse sets its pending flag
// (R17) Elapse in Power Down starts the scheduler
// (R18) Elapse elsewhere only sets pending flag
// (R19) Limit violation sets monitor flag and wakes
// (R20) After violation wake, skip lower priorities
// (R21) Software clears monitor and leftover pending flags
// (R22) Other wakes wait for current monitor task
// (R23) Zero writes and mask writes keep flags
// (R24) Masked events still set their flag
`ifndef WRC_CONSTS_SVH
`define WRC_CONSTS_SVH
`define WRC_CLK_HZ 50000000
`define WRC_LP_HZ 2200
`define WRC_MP_HZ 90000
`define WRC_PRE_W 9
`define WRC_POST_W 12
`define WRC_MON_W 10
`define WRC_SMP_W 16
`define WRC_LIM_W 16
`define WRC_NEV 10
`define WRC_NMON 3
`define WRC_B_IT 0
`define WRC_B_GPT 1
`define WRC_B_SMP 3
`define WRC_B_LF 4
`define WRC_B_MON 5
`define WRC_B_PIN 8
`define WRC_B_TSD 9
`define WRC_UNMASKABLE 10'h201
`define WRC_MON_BITS 10'h0e0
`define WRC_EL_IDLE 10'h11f
`define WRC_EL_STBY 10'h119
`define WRC_EL_PDN 10'h111
`define WRC_EL_MON 10'h1f1
`define WRC_EL_TSD 10'h200
`define WRC_A_FLAG 8'h00
`define WRC_A_MASK 8'h04
`define WRC_A_STATE 8'h08
`define WRC_A_SMP 8'h0c
`define WRC_A_IT 8'h10
`define WRC_A_MPRE 8'h14
`define WRC_A_MPEND 8'h18
`define WRC_A_PRIO 8'h1c
`define WRC_A_LIM 8'h20
`define WRC_A_PIN 8'h2c
`define WRC_SMP_EN 31
`define WRC_ST_BUSY 4
`define WRC_MASK_RST 10'h000
`define WRC_IT_RST 12'hfff
`define WRC_PRIO_RST 6'h24
`define WRC_LIM_RST 32'hffff0000
`endif

/* wrc_pkg.sv */
// Types shared by the wake-up and resume controller
package wrc_pkg;
	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_IDLE = 3'b001,
		ST_STBY = 3'b010,
		ST_PDN = 3'b011,
		ST_TSD = 3'b100,
		ST_MON = 3'b101
	} wrc_state_t;
	typedef enum logic [1:0] {
		SC_IDLE = 2'b00,
		SC_PICK = 2'b01,
		SC_MEAS = 2'b10,
		SC_CMP = 2'b11
	} wrc_sch_t;
endpackage

/* wrc_tk_if.sv */
// Interval timer ticks between the timer and the controller core
`include "wrc_consts.svh"
interface wrc_tk_if;
	logic pre_tick;
	logic it_evt;
	logic [`WRC_POST_W-1:0] it_reload;
	modport tmr(input it_reload, output pre_tick, output it_evt);
	modport core(output it_reload, input pre_tick, input it_evt);
endinterface

/* wrc_div.sv */
// Clock-enable divider standing in for a slow RC oscillator
`include "wrc_consts.svh"
module wrc_div #(
	parameter int DIV = 2
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	output logic tick_o
);
	localparam int W = $clog2(DIV);
	logic [W-1:0] cnt_r;
	logic last;

	if (DIV < 2) begin : g_bad
		$error("wrc_div: DIV must be at least 2");
	end

	assign last = (cnt_r == W'(DIV - 1));

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= '0;
			tick_o <= 1'h0;
		end else begin
			tick_o <= last; // R10
			cnt_r <= last ? '0 : W'(cnt_r + 1'h1);
		end
	end

	a_div_rate: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R10
		tick_o |-> $past(cnt_r) == W'(DIV - 1))
		else $error("divider tick off rate");
endmodule

/* wrc_itimer.sv */
// Interval timer: free pre-counter on the low-power tick plus reloading post-counter
`include "wrc_consts.svh"
module wrc_itimer #(
	parameter int LP_DIV = `WRC_CLK_HZ / `WRC_LP_HZ
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	wrc_tk_if.tmr tk
);
	logic lp_tick;
	logic [`WRC_PRE_W-1:0] pre_r;
	logic [`WRC_POST_W-1:0] post_r;

	wrc_div #(.DIV(LP_DIV)) u_lp (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .tick_o(lp_tick));

	// No enable input at all: the timer cannot be stopped
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pre_r <= '0;
			tk.pre_tick <= 1'h0;
		end else begin
			if (lp_tick) begin
				pre_r <= `WRC_PRE_W'(pre_r + 1'h1); // R11 R13
			end
			tk.pre_tick <= lp_tick && (&pre_r); // R12
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			post_r <= `WRC_IT_RST;
			tk.it_evt <= 1'h0;
		end else begin
			tk.it_evt <= tk.pre_tick && (post_r == '0); // R11 R12
			// A shorter reload cuts the running count short, so a new interval
			// need not wait out the remainder of a long old one
			if (tk.pre_tick) begin
				if (post_r == '0 || post_r > tk.it_reload) begin
					post_r <= tk.it_reload;
				end else begin
					post_r <= `WRC_POST_W'(post_r - 1'h1);
				end
			end
		end
	end

	a_pre_free: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R13
		lp_tick |=> pre_r == $past(pre_r) + 1'h1)
		else $error("pre-counter missed a tick");
	a_post_clock: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R12
		tk.it_evt |-> $past(tk.pre_tick) && $past(post_r) == '0)
		else $error("interval event without pre-counter wrap");
endmodule

/* wrc_top.sv */
// Wake-up and resume controller: bus slave, wake flags, timers, monitor scheduler
`include "wrc_consts.svh"
module wrc_top
	import wrc_pkg::*;
#(
	parameter int LP_DIV = `WRC_CLK_HZ / `WRC_LP_HZ,
	parameter int MP_DIV = `WRC_CLK_HZ / `WRC_MP_HZ
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [1:0] gpt_evt_i,
	input wire logic lf_evt_i,
	input wire logic wake_pin_a_i,
	input wire logic wake_pin_b_i,
	input wire logic temp_ok_i,
	output logic meas_req_o,
	output logic [1:0] meas_sel_o,
	input wire logic meas_done_i,
	input wire logic [`WRC_LIM_W-1:0] meas_val_i,
	output logic wake_o,
	output logic resume_o,
	output logic [2:0] state_o
);
	localparam int NEV = `WRC_NEV;
	localparam int NM = `WRC_NMON;
	localparam int MW = `WRC_MON_W;

	if (LP_DIV < 2 || MP_DIV < 2) begin : g_bad
		$error("wrc_top: dividers must be at least 2");
	end

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] be_mask(input logic [3:0] be);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[8*i +: 8] = {8{be[i]}};
		end
		return m;
	endfunction

	function automatic logic [31:0] upd(input logic [31:0] o, input logic [31:0] d,
		input logic [31:0] m);
		return (o & ~m) | (d & m);
	endfunction

	function automatic logic [NEV-1:0] elig_f(input wrc_state_t s);
		case (s)
			ST_IDLE: elig_f = `WRC_EL_IDLE;
			ST_STBY: elig_f = `WRC_EL_STBY;
			ST_PDN: elig_f = `WRC_EL_PDN;
			ST_MON: elig_f = `WRC_EL_MON;
			ST_TSD: elig_f = `WRC_EL_TSD;
			default: elig_f = '0;
		endcase
	endfunction

	function automatic logic [NM-1:0] onehot(input logic [1:0] s);
		return NM'(3'h1 << s);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	wrc_tk_if tk();
	wrc_state_t st_r;
	wrc_sch_t sc_r;
	logic mp_tick;
	logic wait_r;
	logic [31:0] rdata_r, rd_v, wm;
	logic wr_acc;
	logic [NEV-1:0] flags_r, mask_r, mask_eff, ev, flag_clr, go_v, go_ext;
	logic [NM-1:0] pend_r, pend_set, pend_clr;
	logic [`WRC_SMP_W-1:0] smp_per_r, smp_cnt_r;
	logic smp_en_r, smp_evt, smp_run;
	logic [`WRC_POST_W-1:0] it_rl_r;
	logic [NM*MW-1:0] mpre_r;
	logic [2*NM-1:0] prio_r;
	logic [31:0] lim_r [NM];
	logic [MW-1:0] mcnt_r [NM];
	logic pin_en_r, pin_sel_r, pin_evt;
	logic pa_s1, pa_s2, pa_s3, pb_s1, pb_s2, pb_s3, tp_s1, tp_s2;
	logic [1:0] sel_r, pick_q;
	logic [`WRC_LIM_W-1:0] val_r;
	logic pick_ok, viol, mon_hit, mon_go, wpend_r, st_wr;

	wrc_itimer #(.LP_DIV(LP_DIV)) u_it (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .tk(tk.tmr));
	wrc_div #(.DIV(MP_DIV)) u_mp (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .tick_o(mp_tick));

	assign tk.it_reload = it_rl_r;
	assign avs_readdata_o = rdata_r;
	assign avs_waitrequest_o = wait_r;
	assign state_o = st_r;
	assign meas_sel_o = sel_r;

	////////////////////////////////////////////////////////////////////////////
	// Pins and the temperature detector are asynchronous
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{pa_s1, pa_s2, pa_s3} <= 3'h0;
			{pb_s1, pb_s2, pb_s3} <= 3'h0;
			{tp_s1, tp_s2} <= 2'h0;
		end else begin
			{pa_s1, pa_s2, pa_s3} <= {wake_pin_a_i, pa_s1, pa_s2};
			{pb_s1, pb_s2, pb_s3} <= {wake_pin_b_i, pb_s1, pb_s2};
			{tp_s1, tp_s2} <= {temp_ok_i, tp_s1};
		end
	end

	assign pin_evt = pin_en_r && (pin_sel_r ? (pb_s2 && !pb_s3) : (pa_s2 && !pa_s3));

	////////////////////////////////////////////////////////////////////////////
	// Avalon slave: one wait cycle, then waitrequest low for exactly one cycle
	assign wr_acc = avs_write_i && !wait_r;
	assign wm = be_mask(avs_byteenable_i);
	assign st_wr = wr_acc && avs_address_i == `WRC_A_STATE && avs_byteenable_i[0];

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_r <= 1'h1;
			rdata_r <= '0;
		end else begin
			wait_r <= !(wait_r && (avs_read_i || avs_write_i));
			if (wait_r && avs_read_i) begin
				rdata_r <= rd_v;
			end
		end
	end

	always_comb begin
		rd_v = '0;
		case (avs_address_i)
			`WRC_A_FLAG: rd_v[NEV-1:0] = flags_r;
			`WRC_A_MASK: rd_v[NEV-1:0] = mask_eff;
			`WRC_A_STATE: rd_v = {27'h0, sc_r != SC_IDLE, 1'h0, st_r};
			`WRC_A_SMP: rd_v = {smp_en_r, 15'h0, smp_per_r};
			`WRC_A_IT: rd_v[`WRC_POST_W-1:0] = it_rl_r;
			`WRC_A_MPRE: rd_v[NM*MW-1:0] = mpre_r;
			`WRC_A_MPEND: rd_v[NM-1:0] = pend_r;
			`WRC_A_PRIO: rd_v[2*NM-1:0] = prio_r;
			`WRC_A_PIN: rd_v[1:0] = {pin_sel_r, pin_en_r};
			default: begin
				for (int i = 0; i < NM; i++) begin
					if (avs_address_i == 8'(`WRC_A_LIM + 4 * i)) begin
						rd_v = lim_r[i];
					end
				end
			end
		endcase
	end

	// Configuration registers
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mask_r <= `WRC_MASK_RST;
			smp_en_r <= 1'h0;
			smp_per_r <= '0;
			it_rl_r <= `WRC_IT_RST;
			mpre_r <= '0;
			prio_r <= `WRC_PRIO_RST;
			pin_en_r <= 1'h0;
			pin_sel_r <= 1'h0;
			for (int i = 0; i < NM; i++) begin
				lim_r[i] <= `WRC_LIM_RST;
			end
		end else if (wr_acc) begin
			case (avs_address_i)
				`WRC_A_MASK: mask_r <= NEV'(upd(32'(mask_r), avs_writedata_i, wm));
				`WRC_A_SMP: begin
					smp_per_r <= `WRC_SMP_W'(upd(32'(smp_per_r), avs_writedata_i, wm));
					if (wm[`WRC_SMP_EN]) begin
						smp_en_r <= avs_writedata_i[`WRC_SMP_EN];
					end
				end
				`WRC_A_IT: it_rl_r <= `WRC_POST_W'(upd(32'(it_rl_r), avs_writedata_i, wm));
				`WRC_A_MPRE: mpre_r <= (NM*MW)'(upd(32'(mpre_r), avs_writedata_i, wm));
				`WRC_A_PRIO: prio_r <= (2*NM)'(upd(32'(prio_r), avs_writedata_i, wm));
				`WRC_A_PIN: begin
					if (wm[0]) begin
						{pin_sel_r, pin_en_r} <= avs_writedata_i[1:0];
					end
				end
				default: begin
					for (int i = 0; i < NM; i++) begin
						if (avs_address_i == 8'(`WRC_A_LIM + 4 * i)) begin
							lim_r[i] <= upd(lim_r[i], avs_writedata_i, wm);
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Event vector, masking and state eligibility
	assign mask_eff = mask_r & ~`WRC_UNMASKABLE; // R05
	assign viol = val_r < lim_r[sel_r][`WRC_LIM_W-1:0] || val_r > lim_r[sel_r][31:16]; // R19
	assign mon_hit = (sc_r == SC_CMP) && viol;

	always_comb begin
		ev = '0;
		ev[`WRC_B_IT] = tk.it_evt;
		ev[`WRC_B_GPT +: 2] = gpt_evt_i;
		ev[`WRC_B_SMP] = smp_evt;
		ev[`WRC_B_LF] = lf_evt_i;
		ev[`WRC_B_MON +: NM] = mon_hit ? onehot(sel_r) : '0;
		ev[`WRC_B_PIN] = pin_evt;
		ev[`WRC_B_TSD] = (st_r == ST_TSD) && tp_s2;
	end

	assign go_v = ev & ~mask_eff & elig_f(st_r); // R06 R07
	assign go_ext = go_v & ~`WRC_MON_BITS;
	assign mon_go = |(go_v & `WRC_MON_BITS);
	assign flag_clr = (wr_acc && avs_address_i == `WRC_A_FLAG) ?
		avs_writedata_i[NEV-1:0] & wm[NEV-1:0] : '0;

	// Set wins over a clear in the same cycle; flags drop only on a one written
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flags_r <= '0;
		end else begin
			flags_r <= (flags_r & ~flag_clr) | ev; // R01 R03 R04 R23 R24
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sampling timer: period is smp_per_r + 1 ticks of the medium-power tick
	assign smp_run = st_r == ST_RUN || st_r == ST_IDLE || st_r == ST_STBY;
	assign smp_evt = smp_en_r && mp_tick && smp_run && smp_cnt_r == '0; // R08

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			smp_cnt_r <= '0;
		end else if (!smp_en_r) begin
			smp_cnt_r <= smp_per_r;
		end else if (mp_tick && smp_run) begin
			smp_cnt_r <= (smp_cnt_r == '0) ? smp_per_r : `WRC_SMP_W'(smp_cnt_r - 1'h1); // R09 R10
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Monitor interval counters, one per quantity
	for (genvar g = 0; g < NM; g++) begin : g_mon
		logic [MW-1:0] pre_v;
		assign pre_v = mpre_r[g*MW +: MW];
		assign pend_set[g] = tk.pre_tick && pre_v != '0 && mcnt_r[g] == MW'(1); // R15 R16

		always_ff @(posedge mclk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				mcnt_r[g] <= '0;
			end else if (pre_v == '0) begin
				mcnt_r[g] <= '0; // R14
			end else if (mcnt_r[g] == '0) begin
				mcnt_r[g] <= pre_v;
			end else if (tk.pre_tick) begin
				mcnt_r[g] <= (mcnt_r[g] == MW'(1)) ? pre_v : MW'(mcnt_r[g] - 1'h1); // R14 R15
			end
		end

		a_mon_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R14
			pre_v == '0 |-> !pend_set[g])
			else $error("disabled monitor raised pending");
	end

	assign pend_clr = ((wr_acc && avs_address_i == `WRC_A_MPEND) ?
		avs_writedata_i[NM-1:0] & wm[NM-1:0] : '0) | ((sc_r == SC_CMP) ? onehot(sel_r) : '0);

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend_r <= '0;
		end else begin
			pend_r <= (pend_r & ~pend_clr) | pend_set; // R16 R18 R21
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Scheduler pick: first pending quantity in programmed order
	always_comb begin
		logic [1:0] q;
		q = '0;
		pick_ok = 1'h0;
		pick_q = '0;
		for (int k = 0; k < NM; k++) begin
			q = prio_r[2*k +: 2];
			if (!pick_ok && q < 2'h3 && pend_r[q]) begin
				pick_ok = 1'h1;
				pick_q = q;
			end
		end
	end

	// Wakes during a monitor task are held until the task is done
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wpend_r <= 1'h0;
		end else if (st_r != ST_MON) begin
			wpend_r <= 1'h0;
		end else if (|go_ext) begin
			wpend_r <= 1'h1; // R22
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sc_r <= SC_IDLE;
			sel_r <= '0;
			val_r <= '0;
			meas_req_o <= 1'h0;
		end else begin
			meas_req_o <= 1'h0;
			case (sc_r)
				SC_IDLE: begin
					if (st_r == ST_PDN && !(|go_v) && |pend_set) begin
						sc_r <= SC_PICK; // R17
					end
				end
				SC_PICK: begin
					if (wpend_r || |go_ext || !pick_ok) begin
						sc_r <= SC_IDLE; // R22
					end else begin
						sel_r <= pick_q; // R17
						meas_req_o <= 1'h1;
						sc_r <= SC_MEAS;
					end
				end
				SC_MEAS: begin
					if (meas_done_i) begin
						val_r <= meas_val_i;
						sc_r <= SC_CMP;
					end
				end
				SC_CMP: sc_r <= mon_go ? SC_IDLE : SC_PICK; // R20
				default: sc_r <= SC_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Device state; software enters low-power states only from Run
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= ST_RUN;
			wake_o <= 1'h0;
			resume_o <= 1'h0;
		end else begin
			wake_o <= 1'h0;
			resume_o <= 1'h0;
			case (st_r)
				ST_RUN: begin
					if (st_wr && avs_writedata_i[2:0] inside {ST_IDLE, ST_STBY, ST_PDN, ST_TSD}) begin
						st_r <= wrc_state_t'(avs_writedata_i[2:0]);
					end
				end
				ST_IDLE, ST_STBY: begin
					if (|go_v) begin
						st_r <= ST_RUN; // R02
						resume_o <= 1'h1;
					end
				end
				ST_PDN: begin
					if (|go_v) begin
						st_r <= ST_RUN; // R02
						wake_o <= 1'h1;
					end else if (|pend_set) begin
						st_r <= ST_MON; // R17
					end
				end
				ST_MON: begin
					if (sc_r == SC_PICK && (wpend_r || |go_ext)) begin
						st_r <= ST_RUN; // R22
						wake_o <= 1'h1;
					end else if (sc_r == SC_CMP && mon_go) begin
						st_r <= ST_RUN; // R19 R20
						wake_o <= 1'h1;
					end else if (sc_r == SC_PICK && !pick_ok) begin
						st_r <= ST_PDN;
					end
				end
				ST_TSD: begin
					if (|go_v) begin
						st_r <= ST_RUN; // R02 R05
						wake_o <= 1'h1;
					end
				end
				default: st_r <= ST_RUN;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	a_flag_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R01
		|ev |=> (flags_r & $past(ev)) == $past(ev))
		else $error("event did not set its flag");
	a_flag_sticky: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R04
		1'h1 |=> (flags_r & $past(flags_r & ~flag_clr)) == $past(flags_r & ~flag_clr))
		else $error("wake flag cleared itself");
	a_mask_keep: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R23
		wr_acc && avs_address_i == `WRC_A_MASK |=> (flags_r & $past(flags_r)) == $past(flags_r))
		else $error("mask write changed flags");
	a_it_unmask: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R05
		st_r == ST_PDN && tk.it_evt |=> st_r == ST_RUN && wake_o)
		else $error("interval timer did not wake");
	a_mask_block: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R06
		st_r == ST_IDLE && ev == NEV'(1 << `WRC_B_GPT) && mask_r[`WRC_B_GPT] |=> st_r == ST_IDLE)
		else $error("masked timer resumed");
	a_gpt_stby: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R07
		st_r == ST_STBY && (ev & ~NEV'(3 << `WRC_B_GPT)) == '0 |=> st_r == ST_STBY)
		else $error("general timer resumed Stand-By");
	a_smp_reload: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R09
		smp_evt |=> smp_cnt_r == $past(smp_per_r) && flags_r[`WRC_B_SMP])
		else $error("sampling timer did not restart");
	a_mon_start: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R17
		st_r == ST_PDN && |pend_set && !(|go_v) |=> st_r == ST_MON && sc_r == SC_PICK)
		else $error("scheduler did not start");
	a_meas_pdn: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R18
		meas_req_o |-> $past(st_r) == ST_MON && st_r == ST_MON)
		else $error("measurement outside monitor run");
	a_viol_wake: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R19 R20
		mon_go |=> st_r == ST_RUN && wake_o && sc_r == SC_IDLE)
		else $error("violation did not wake");
	a_task_whole: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R22
		sc_r == SC_MEAS |=> st_r == ST_MON)
		else $error("monitor task aborted");

	c_it_wake: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		st_r == ST_PDN && tk.it_evt ##1 wake_o);
	c_mon_viol: cover property (@(posedge mclk_i) disable iff (!rst_n_i) mon_go);
	c_defer: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		sc_r == SC_MEAS && |go_ext);
	c_resume: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		st_r == ST_STBY && smp_evt ##1 resume_o);
endmodule

/* wrc_meas_model.sv */
// Measurement unit model answering the controller's measurement requests
module wrc_meas_model #(
	parameter int DLY = 5
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic req_i,
	input wire logic [1:0] sel_i,
	input wire logic [47:0] vals_i,
	output logic done_o,
	output logic [15:0] val_o
);
	int cnt;
	logic [1:0] sel_r;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= 0;
			sel_r <= 2'h0;
			done_o <= 1'b0;
			val_o <= 16'h0000;
		end else begin
			done_o <= 1'b0;
			// Result is only valid with done, so it churns otherwise
			val_o <= ~val_o;
			if (req_i) begin
				cnt <= DLY;
				sel_r <= sel_i;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
			end
			if (!req_i && cnt == 1) begin
				done_o <= 1'b1;
				val_o <= vals_i[sel_r*16 +: 16];
			end
		end
	end
endmodule

/* wakeup_resume_controller_test.sv */
// Self-checking bench of the wake-up and resume controller
module wakeup_resume_controller_test
	import wrc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] adr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat;
	logic [31:0] rq;
	logic wtr;
	logic [1:0] gpt = 2'h0;
	logic lf = 1'b0;
	logic pina = 1'b0;
	logic tok = 1'b0;
	logic req, done, wake, res;
	logic [1:0] sel;
	logic [15:0] mval;
	logic [2:0] st;
	logic [47:0] vals = 48'h0;
	int n_errors = 0;
	int samples_checked = 0;
	int n_wake = 0;
	int n_res = 0;
	int n_meas = 0;
	wrc_top #(.LP_DIV(4), .MP_DIV(3)) u_wrc_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wtr),
		.gpt_evt_i(gpt), .lf_evt_i(lf), .wake_pin_a_i(pina), .wake_pin_b_i(1'b0),
		.temp_ok_i(tok), .meas_req_o(req), .meas_sel_o(sel), .meas_done_i(done),
		.meas_val_i(mval), .wake_o(wake), .resume_o(res), .state_o(st));
	wrc_meas_model u_wrc_meas_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req),
		.sel_i(sel), .vals_i(vals), .done_o(done), .val_o(mval));
	initial begin
		forever #10 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		if (wake === 1'b1) n_wake++;
		if (res === 1'b1) n_res++;
		if (req === 1'b1) n_meas++;
	end
	////////////////////////////////////////////////////////////////
	task report_and_stop;
		if (n_errors == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk_i);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge mclk_i);
			n++;
		end while (wtr !== 1'b0 && n < 40);
		rq = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		if (n == 40) chk(32'h1, 32'h0);
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rq, e);
	endtask
	task ev(input logic [1:0] g, input logic l);
		@(posedge mclk_i);
		gpt <= g;
		lf <= l;
		@(posedge mclk_i);
		gpt <= 2'h0;
		lf <= 1'b0;
	endtask
	// Bounded wait for the next wake or resume pulse
	task wev(input int lim);
		int s;
		s = n_wake + n_res;
		for (int i = 0; i < lim && n_wake + n_res == s; i++) @(posedge mclk_i);
	endtask
	// Enter a low state, send events, see whether it came back to Run
	task lowev(input logic [2:0] s, input logic [1:0] g, input logic l, input logic e);
		int r;
		r = n_res + n_wake;
		bus(1'b1, 8'h08, {29'h0, s});
		ev(g, l);
		wev(20);
		chk(n_res + n_wake - r, e);
		chk(st, e ? ST_RUN : s);
		if (!e) ev(2'b00, 1'b1);
		wev(20);
	endtask
	////////////////////////////////////////////////////////////////
	task t_regs;
		rchk(8'h04, 32'h0);
		rchk(8'h10, 32'hfff);
		rchk(8'h1c, 32'h24);
		rchk(8'h20, 32'hffff0000);
		bus(1'b1, 8'h30, 32'hffffffff);
		rchk(8'h30, 32'h0);
	endtask
	task t_flags;
		ev(2'b01, 1'b0);
		rchk(8'h00, 32'h2);
		bus(1'b1, 8'h00, 32'h0);
		rchk(8'h00, 32'h2);
		bus(1'b1, 8'h04, 32'h3ff);
		rchk(8'h00, 32'h2);
		rchk(8'h04, 32'h1fe);
		repeat (200) @(posedge mclk_i);
		rchk(8'h00, 32'h2);
		bus(1'b1, 8'h00, 32'h2);
		rchk(8'h00, 32'h0);
	endtask
	task t_resume;
		bus(1'b1, 8'h04, 32'h2);
		lowev(3'd1, 2'b10, 1'b0, 1'b1);
		lowev(3'd1, 2'b01, 1'b0, 1'b0);
		rchk(8'h00, 32'h16);
		lowev(3'd2, 2'b10, 1'b0, 1'b0);
		lowev(3'd2, 2'b00, 1'b1, 1'b1);
		lowev(3'd3, 2'b00, 1'b1, 1'b1);
		bus(1'b1, 8'h00, 32'h3ff);
	endtask
	task t_smp;
		bus(1'b1, 8'h0c, 32'h80000004);
		lowev(3'd2, 2'b00, 1'b0, 1'b1);
		lowev(3'd2, 2'b00, 1'b0, 1'b1);
		rchk(8'h00, 32'h8);
		bus(1'b1, 8'h0c, 32'h0);
		bus(1'b1, 8'h00, 32'h3ff);
	endtask
	task t_mon;
		int m;
		vals <= {16'd0, 16'd15, 16'd30};
		bus(1'b1, 8'h20, {16'd20, 16'd10});
		bus(1'b1, 8'h24, {16'd20, 16'd10});
		bus(1'b1, 8'h14, 32'h401);
		bus(1'b1, 8'h08, 32'h3);
		wev(2600);
		chk(st, ST_RUN);
		rchk(8'h00, 32'h20);
		rchk(8'h18, 32'h2);
		chk(n_meas, 1);
		bus(1'b1, 8'h00, 32'h20);
		bus(1'b1, 8'h18, 32'h2);
		rchk(8'h18, 32'h0);
		vals[15:0] <= 16'd15;
		m = n_meas;
		bus(1'b1, 8'h08, 32'h3);
		repeat (2600) @(posedge mclk_i);
		chk(n_meas - m, 2);
		chk(st, ST_PDN);
		rchk(8'h18, 32'h0);
		ev(2'b00, 1'b1);
		wev(20);
		m = n_meas;
		repeat (2600) @(posedge mclk_i);
		chk(n_meas, m);
		rchk(8'h18, 32'h3);
		bus(1'b1, 8'h14, 32'h0);
		bus(1'b1, 8'h18, 32'h3);
		repeat (2600) @(posedge mclk_i);
		rchk(8'h18, 32'h0);
		bus(1'b1, 8'h00, 32'h3ff);
	endtask
	task t_it;
		bus(1'b1, 8'h04, 32'h3ff);
		bus(1'b1, 8'h10, 32'h0);
		bus(1'b1, 8'h08, 32'h3);
		wev(5000);
		chk(st, ST_RUN);
		rchk(8'h00, 32'h1);
	endtask
	// Pin wake from Power Down, then thermal release with every mask set
	task t_pins;
		int w;
		bus(1'b1, 8'h04, 32'h0);
		bus(1'b1, 8'h2c, 32'h1);
		bus(1'b1, 8'h00, 32'h3ff);
		w = n_wake;
		bus(1'b1, 8'h08, 32'h3);
		pina <= 1'b1;
		wev(20);
		chk(n_wake - w, 1);
		chk(st, ST_RUN);
		rchk(8'h00, 32'h100);
		bus(1'b1, 8'h04, 32'h3ff);
		bus(1'b1, 8'h00, 32'h3ff);
		bus(1'b1, 8'h08, 32'h4);
		repeat (20) @(posedge mclk_i);
		chk(st, ST_TSD);
		tok <= 1'b1;
		wev(20);
		chk(st, ST_RUN);
		rchk(8'h00, 32'h200);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge mclk_i);
		n_errors++;
		report_and_stop();
	end
	initial begin
		repeat (16) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		t_regs();
		t_flags();
		t_resume();
		t_smp();
		t_mon();
		t_it();
		t_pins();
		report_and_stop();
	end
endmodule
